// file: sector_protect_global_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module sector_protect_global_ctrl #(
    parameter int NUM_SECTORS = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_wp_n,
    input wire logic i_write_enable_latch,
    output logic o_so,
    output logic o_so_oe,
    output logic o_protect_regs_lock,
    output logic [1:0] o_soft_protect_summary,
    output logic [NUM_SECTORS-1:0] o_sector_protect
);
    localparam int SW = (NUM_SECTORS > 1) ? $clog2(NUM_SECTORS) : 1;

    spi_byte_if bus ();

    sector_protect_pkg::state_t state_q;
    logic [NUM_SECTORS-1:0] sector_q;
    logic lock_q;
    logic wp_meta_q;
    logic wp_sync_q;
    logic [1:0] addr_cnt_q;
    logic [15:0] addr_q;
    logic so_q;
    logic oe_q;
    logic [1:0] summary_q;
    logic wr_fire;
    logic wr_ok;
    logic hw_locked;
    logic addr_last;
    logic [3:0] glob;
    logic [SW-1:0] sel;

    function automatic logic [1:0] summarize(input logic [NUM_SECTORS-1:0] v);
        if (&v) begin
            summarize = sector_protect_pkg::SUMMARY_ALL;
        end else if (|v) begin
            summarize = sector_protect_pkg::SUMMARY_SOME;
        end else begin
            summarize = sector_protect_pkg::SUMMARY_NONE;
        end
    endfunction : summarize

    // Addresses past the last sector fold onto the top sector
    function automatic logic [SW-1:0] sector_of(input logic [sector_protect_pkg::ADDR_WIDTH-1:0] a);
        logic [7:0] raw;
        raw = a[sector_protect_pkg::SECT_ADDR_LSB +: 8];
        if (int'(raw) >= NUM_SECTORS) begin
            sector_of = SW'(NUM_SECTORS - 1);
        end else begin
            sector_of = raw[SW-1:0];
        end
    endfunction : sector_of

    spi_byte_front u_front (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_sck(i_sck),
        .i_cs_n(i_cs_n),
        .i_si(i_si),
        .bus(bus.front)
    );

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wp_meta_q <= 1'b1;
            wp_sync_q <= 1'b1;
        end else begin
            wp_meta_q <= i_wp_n;
            wp_sync_q <= wp_meta_q;
        end
    end

    assign wr_fire = (state_q == sector_protect_pkg::ST_WDATA) && bus.byte_valid;
    assign hw_locked = ~wp_sync_q & lock_q;
    assign wr_ok = wr_fire & i_write_enable_latch & ~hw_locked;
    assign glob = bus.byte_data[sector_protect_pkg::GLOB_MSB:sector_protect_pkg::GLOB_LSB];
    assign addr_last = (addr_cnt_q == 2'(sector_protect_pkg::ADDR_BYTES - 1));
    assign sel = sector_of({addr_q, bus.byte_data});

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_q <= sector_protect_pkg::ST_CMD;
        end else if (!bus.cs_active) begin
            state_q <= sector_protect_pkg::ST_CMD;
        end else if (bus.byte_valid) begin
            unique case (state_q)
                sector_protect_pkg::ST_CMD: begin
                    if (bus.byte_data == sector_protect_pkg::OP_WRITE_STATUS) begin
                        state_q <= sector_protect_pkg::ST_WDATA;
                    end else if (bus.byte_data == sector_protect_pkg::OP_READ_PROTECT) begin
                        state_q <= sector_protect_pkg::ST_ADDR;
                    end else begin
                        state_q <= sector_protect_pkg::ST_SKIP;
                    end
                end
                sector_protect_pkg::ST_ADDR: begin
                    if (addr_last) begin
                        state_q <= sector_protect_pkg::ST_RDOUT;
                    end
                end
                sector_protect_pkg::ST_WDATA: state_q <= sector_protect_pkg::ST_SKIP;
                sector_protect_pkg::ST_RDOUT: state_q <= sector_protect_pkg::ST_RDOUT;
                sector_protect_pkg::ST_SKIP: state_q <= sector_protect_pkg::ST_SKIP;
                default: state_q <= sector_protect_pkg::ST_CMD;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            addr_cnt_q <= 2'h0;
            addr_q <= 16'h0000;
        end else if (state_q != sector_protect_pkg::ST_ADDR) begin
            addr_cnt_q <= 2'h0;
        end else if (bus.byte_valid) begin
            addr_cnt_q <= addr_cnt_q + 2'h1;
            addr_q <= {addr_q[7:0], bus.byte_data};
        end
    end

    // Global decode only while unlocked; a lock-clearing write cannot also act
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sector_q <= {NUM_SECTORS{sector_protect_pkg::SECTOR_RESET}};
        end else if (wr_ok && !lock_q) begin
            if (glob == sector_protect_pkg::GLOB_ALL_ONES) begin
                sector_q <= {NUM_SECTORS{1'b1}};
            end else if (glob == sector_protect_pkg::GLOB_ALL_ZEROS) begin
                sector_q <= {NUM_SECTORS{1'b0}};
            end
            // Mixed patterns fall through and keep every sector bit
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            lock_q <= sector_protect_pkg::LOCK_RESET;
        end else if (wr_ok) begin
            lock_q <= bus.byte_data[sector_protect_pkg::LOCK_BIT];
        end
    end

    // Output is a level copy of the sector bit: every bit of the byte is equal
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            so_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (!bus.cs_active) begin
            oe_q <= 1'b0;
        end else if (state_q == sector_protect_pkg::ST_ADDR && bus.byte_valid && addr_last) begin
            so_q <= sector_q[sel];
            oe_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            summary_q <= sector_protect_pkg::SUMMARY_ALL;
        end else begin
            summary_q <= summarize(sector_q);
        end
    end

    assign o_so = so_q;
    assign o_so_oe = oe_q;
    assign o_protect_regs_lock = lock_q;
    assign o_soft_protect_summary = summary_q;
    assign o_sector_protect = sector_q;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_write_unlocked;
        wr_fire && i_write_enable_latch && !lock_q;
    endsequence

    sequence s_read_addr_done;
        state_q == sector_protect_pkg::ST_ADDR && bus.byte_valid && addr_last && bus.cs_active;
    endsequence

    glob_protect_a: assert property (s_write_unlocked and (glob == 4'hF) |=> &sector_q)
        else $error("global protect did not set all sectors");
    glob_unprotect_a: assert property (s_write_unlocked and (glob == 4'h0) |=> sector_q == '0)
        else $error("global unprotect did not clear all sectors");
    mixed_hold_a: assert property (wr_fire && glob != 4'hF && glob != 4'h0 |=> $stable(sector_q))
        else $error("mixed pattern changed sector bits");
    hw_lock_a: assert property (wr_fire && !wp_sync_q && lock_q |=> $stable(sector_q) && lock_q)
        else $error("write acted under hardware lock");
    soft_lock_a: assert property (wr_fire && i_write_enable_latch && wp_sync_q && lock_q
        |=> $stable(sector_q) && lock_q == $past(bus.byte_data[7]))
        else $error("soft lock write handled wrongly");
    lock_follow_a: assert property (s_write_unlocked |=> lock_q == $past(bus.byte_data[7]))
        else $error("lock bit did not follow bit 7");
    no_enable_a: assert property (wr_fire && !i_write_enable_latch |=> $stable(sector_q) && $stable(lock_q))
        else $error("write executed without enable latch");
    read_data_a: assert property (s_read_addr_done |=> o_so_oe && o_so == $past(sector_q[sel]))
        else $error("protection read byte wrong");
    cs_end_a: assert property ($fell(bus.cs_active) |=> !o_so_oe)
        else $error("output still driven after chip select rose");
    summary_track_a: assert property (##1 o_soft_protect_summary == summarize($past(sector_q)))
        else $error("summary field out of step");
endmodule : sector_protect_global_ctrl
`default_nettype wire

// file: sector_protect_global_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module sector_protect_global_ctrl_tb_top;
    localparam int NSEC = 8;
    logic clk_sys;
    logic rst;
    logic wp_n;
    logic write_enable_latch;
    logic so_line;
    logic sck;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe;
    logic lock;
    logic [1:0] summary;
    logic [NSEC-1:0] sectors;
    int num_errors = 0;
    int cmp_count = 0;

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    sector_protect_global_ctrl #(.NUM_SECTORS(NSEC)) uut (
        .i_clk_sys(clk_sys), .i_rst(rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
        .i_wp_n(wp_n), .i_write_enable_latch(write_enable_latch), .o_so(so), .o_so_oe(so_oe),
        .o_protect_regs_lock(lock), .o_soft_protect_summary(summary), .o_sector_protect(sectors)
    );

    // Released line reads inverted, so data without enable cannot pass
    assign so_line = so_oe ? so : ~so;

    spi_host_model host (.i_clk_sys(clk_sys), .i_so(so_line), .o_sck(sck), .o_cs_n(cs_n), .o_si(si));

    task automatic compare(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : compare

    task automatic give_verdict;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // Data byte cut to nbits, then extra bits of FFh that must be ignored
    task automatic raw_frame(input logic [7:0] op, input logic [7:0] val, input int nbits, input int extra);
        logic [7:0] rx;
        host.start();
        host.xfer(op, 8, rx);
        host.xfer(val, nbits, rx);
        host.xfer(8'hFF, extra, rx);
        host.stop();
    endtask : raw_frame

    task automatic wr_status(input logic [7:0] val);
        raw_frame(sector_protect_pkg::OP_WRITE_STATUS, val, 8, 0);
    endtask : wr_status

    // Summary expectation derived from the sector pattern itself
    task automatic exp_state(input logic [7:0] sec, input logic lk);
        logic [1:0] sum;
        sum = (&sec) ? sector_protect_pkg::SUMMARY_ALL
            : ((|sec) ? sector_protect_pkg::SUMMARY_SOME : sector_protect_pkg::SUMMARY_NONE);
        compare(sectors, sec);
        compare({7'h00, lock}, {7'h00, lk});
        compare({6'h00, summary}, {6'h00, sum});
    endtask : exp_state

    // Two output bytes, then an abort three bits into the third
    task automatic rd_sector(input logic [23:0] addr, input logic [7:0] exp);
        logic [7:0] rx;
        host.start();
        host.xfer(sector_protect_pkg::OP_READ_PROTECT, 8, rx);
        for (int b = 2; b >= 0; b--) begin
            host.xfer(addr[b*8 +: 8], 8, rx);
        end
        repeat (2) begin
            host.xfer(8'hA5, 8, rx);
            compare(rx, exp);
        end
        compare({7'h00, so_oe}, 8'h01);
        host.xfer(8'h00, 3, rx);
        host.stop();
        compare({7'h00, so_oe}, 8'h00);
    endtask : rd_sector

    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        write_enable_latch = 1'b0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        exp_state(8'hFF, 1'b0);
        wr_status(8'h00);
        exp_state(8'hFF, 1'b0);
        write_enable_latch <= 1'b1;
        rd_sector(24'h05_12_34, 8'hFF);
        wr_status(8'h04);
        exp_state(8'hFF, 1'b0);
        wr_status(8'h38);
        exp_state(8'hFF, 1'b0);
        wr_status(8'h00);
        exp_state(8'h00, 1'b0);
        wp_n <= 1'b0;
        rd_sector(24'h07_FF_FF, 8'h00);
        wp_n <= 1'b1;
        wr_status(8'h7F);
        exp_state(8'hFF, 1'b0);
        wr_status(8'h43);
        exp_state(8'h00, 1'b0);
        wr_status(8'hFF);
        exp_state(8'hFF, 1'b1);
        wp_n <= 1'b0;
        wr_status(8'h0F);
        exp_state(8'hFF, 1'b1);
        rd_sector(24'h00_00_00, 8'hFF);
        wp_n <= 1'b1;
        wr_status(8'h0F);
        exp_state(8'hFF, 1'b0);
        wr_status(8'h00);
        exp_state(8'h00, 1'b0);
        raw_frame(8'h05, 8'hFF, 8, 0);
        exp_state(8'h00, 1'b0);
        raw_frame(sector_protect_pkg::OP_WRITE_STATUS, 8'hFF, 4, 0);
        exp_state(8'h00, 1'b0);
        raw_frame(sector_protect_pkg::OP_WRITE_STATUS, 8'h00, 8, 8);
        exp_state(8'h00, 1'b0);
        wr_status(8'hF0);
        exp_state(8'h00, 1'b1);
        wr_status(8'hBC);
        exp_state(8'h00, 1'b1);
        wr_status(8'h3C);
        exp_state(8'h00, 1'b0);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        exp_state(8'hFF, 1'b0);
        give_verdict();
    end
endmodule : sector_protect_global_ctrl_tb_top
`default_nettype wire

// file: sector_protect_pkg.sv
`default_nettype none
package sector_protect_pkg;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_READ_PROTECT = 8'h3C;
    localparam int BITS_PER_BYTE = 8;
    localparam int ADDR_BYTES = 3;
    localparam int ADDR_WIDTH = 24;
    localparam int SECT_ADDR_LSB = 16;
    localparam int LOCK_BIT = 7;
    localparam int GLOB_MSB = 5;
    localparam int GLOB_LSB = 2;
    localparam logic [3:0] GLOB_ALL_ONES = 4'hF;
    localparam logic [3:0] GLOB_ALL_ZEROS = 4'h0;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic SECTOR_RESET = 1'b1;
    localparam logic [1:0] SUMMARY_NONE = 2'h0;
    localparam logic [1:0] SUMMARY_SOME = 2'h1;
    localparam logic [1:0] SUMMARY_ALL = 2'h3;
    typedef enum logic [4:0] {
        ST_CMD   = 5'h01,
        ST_ADDR  = 5'h02,
        ST_WDATA = 5'h04,
        ST_RDOUT = 5'h08,
        ST_SKIP  = 5'h10
    } state_t;
endpackage : sector_protect_pkg
`default_nettype wire

// file: spi_byte_front.sv
`timescale 1ns/10ps
`default_nettype none
module spi_byte_front (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    spi_byte_if.front bus
);
    localparam int PINS = 3;
    localparam int P_SCK = 0;
    localparam int P_CSN = 1;
    localparam int P_SI = 2;

    logic [PINS-1:0] pins;
    logic [PINS-1:0] meta_q;
    logic [PINS-1:0] sync_q;
    logic sck_prev_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] byte_q;
    logic valid_q;
    logic sck_rise;
    logic cs_act;

    assign pins = {i_si, i_cs_n, i_sck};

    // Link pins come from the host's clock; two stages each
    for (genvar g = 0; g < PINS; g++) begin : g_sync
        always_ff @(posedge i_clk_sys or posedge i_rst) begin
            if (i_rst) begin
                meta_q[g] <= 1'b1;
                sync_q[g] <= 1'b1;
            end else begin
                meta_q[g] <= pins[g];
                sync_q[g] <= meta_q[g];
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sck_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sync_q[P_SCK];
        end
    end

    assign cs_act = ~sync_q[P_CSN];
    assign sck_rise = sync_q[P_SCK] & ~sck_prev_q;

    // Bit count restarts with every frame, so a short frame leaves no residue
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            byte_q <= 8'h00;
            valid_q <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            if (!cs_act) begin
                bit_cnt_q <= 3'h0;
            end else if (sck_rise) begin
                shift_q <= {shift_q[6:0], sync_q[P_SI]};
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (bit_cnt_q == 3'h7) begin
                    byte_q <= {shift_q[6:0], sync_q[P_SI]};
                    valid_q <= 1'b1;
                end
            end
        end
    end

    assign bus.cs_active = cs_act;
    assign bus.byte_valid = valid_q;
    assign bus.byte_data = byte_q;
endmodule : spi_byte_front
`default_nettype wire

// file: spi_byte_if.sv
`timescale 1ns/10ps
`default_nettype none
interface spi_byte_if;
    logic cs_active;
    logic byte_valid;
    logic [7:0] byte_data;
    modport front (output cs_active, output byte_valid, output byte_data);
    modport core (input cs_active, input byte_valid, input byte_data);
endinterface : spi_byte_if
`default_nettype wire

// file: spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    input wire logic i_clk_sys,
    input wire logic i_so,
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si
);
    localparam int HALF_CLKS = 5;

    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : tick

    task automatic start;
        o_cs_n <= 1'b0;
        tick(HALF_CLKS);
    endtask : start

    // Mode 0, MSB first; clock stands low outside frames
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            o_si <= tx[i];
            tick(HALF_CLKS);
            o_sck <= 1'b1;
            rx[i] = i_so;
            tick(HALF_CLKS);
            o_sck <= 1'b0;
        end
    endtask : xfer

    // Released data line toggles so a stale level is never read as valid
    task automatic stop;
        tick(HALF_CLKS);
        o_cs_n <= 1'b1;
        o_si <= ~o_si;
        tick(6);
    endtask : stop
endmodule : spi_host_model
`default_nettype wire
